// File: shared/dilpc_pkg.sv
// constants for the interrupt and low-power controller
// assumes one instruction clock; the input clock runs at twice its rate
package dilpc_pkg;
  localparam int          NUM_SRC        = 10;
  localparam int          NUM_LVL        = 11;
  localparam logic [15:0] VEC_RESET      = 16'h0000;
  localparam logic [15:0] VEC_PDOWN      = 16'h002c;
  localparam logic [15:0] VEC_FIRST      = 16'h0004;
  localparam logic [15:0] VEC_STEP       = 16'h0004;
  // source index = priority order, 0 highest
  localparam int          SRC_PROG_A     = 0;
  localparam int          SRC_LEVEL_B    = 1;
  localparam int          SRC_LEVEL_A    = 2;
  localparam int          SRC_SPA_TX     = 3;
  localparam int          SRC_SPA_RX     = 4;
  localparam int          SRC_EDGE       = 5;
  localparam int          SRC_BYTE_MEM_DMA       = 6;
  localparam int          SRC_SPB_TX     = 7;
  localparam int          SRC_SPB_RX     = 8;
  localparam int          SRC_TIMER      = 9;
  // control word fields
  localparam int          CTL_EDGE_B     = 0;
  localparam int          CTL_EDGE_A     = 1;
  localparam int          CTL_EDGE_PROG  = 2;
  localparam int          CTL_NEST       = 3;
  localparam int          CTL_W          = 4;
  localparam logic [3:0]  CTL_RESET      = 4'h0;
  localparam logic [9:0]  MASK_RESET     = 10'h000;
  localparam int          MODE_STATUS_REG_W        = 7;
  localparam int          STACK_DEPTH    = 12;
  // recovery from power-down, in input clock cycles
  localparam int          RECOVER_RUN_INPUT_CLOCK_PIN = 200;
  localparam int          RECOVER_OSC_INPUT_CLOCK_PIN = 4096;
  localparam int          INPUT_CLOCK_PIN_PER_CYCLE   = 2;
  localparam int          RECOVER_RUN_CYC   = (RECOVER_RUN_INPUT_CLOCK_PIN + INPUT_CLOCK_PIN_PER_CYCLE - 1) / INPUT_CLOCK_PIN_PER_CYCLE;
  localparam int          RECOVER_OSC_CYC   = (RECOVER_OSC_INPUT_CLOCK_PIN + INPUT_CLOCK_PIN_PER_CYCLE - 1) / INPUT_CLOCK_PIN_PER_CYCLE;
  localparam int          RECOVER_W         = 12;
  localparam int          DIV_W             = 7;
  typedef enum logic [1:0] {
    DILPC_RUN     = 2'b00,
    DILPC_IDLE    = 2'b01,
    DILPC_PDOWN   = 2'b11,
    DILPC_RECOVER = 2'b10
  } dilpc_state_t;
endpackage : dilpc_pkg

// File: rtl/dilpc_req_cell.sv
// one pending-request latch with edge or level sensing
// assumes request inputs are synchronous to sys_clk
`timescale 1ns/1ps
module dilpc_req_cell
  import dilpc_pkg::*;
(
  input  wire logic sys_clk,
  input  wire logic reset_n,
  input  wire logic clkEn,
  input  wire logic reqIn,
  input  wire logic edgeMode,
  input  wire logic setPend,
  input  wire logic clrPend,
  input  wire logic ack,
  output logic      pending
);
  logic latch_q;
  logic latch_d;
  logic reqPrev_q;
  logic reqPrev_d;

  always_comb
  begin
    reqPrev_d = reqIn;
    latch_d   = latch_q;
    if (clrPend || ack)
    begin
      latch_d = 1'b0;
    end
    // a new edge or a force beats a clear in the same cycle
    if ((edgeMode && reqIn && !reqPrev_q) || setPend)
    begin
      latch_d = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      latch_q   <= 1'b0;
      reqPrev_q <= 1'b0;
    end
    else if (clkEn)
    begin
      latch_q   <= latch_d;
      reqPrev_q <= reqPrev_d;
    end
  end

  assign pending = latch_q | (!edgeMode & reqIn);
endmodule : dilpc_req_cell

// File: rtl/dilpc_ctrl.sv
// interrupt prioritiser, status stack and low-power sequencing
// assumes the sequencer pulses its strobes for one sys_clk at instruction boundaries
`timescale 1ns/1ps
module dilpc_ctrl
  import dilpc_pkg::*;
#(
  parameter int STATUS_W = 16
)
(
  input  wire logic                sys_clk,
  input  wire logic                reset_n,
  input  wire logic                clkEn,
  input  wire logic                extReqProgA_n,
  input  wire logic                extReqLevelA_n,
  input  wire logic                extReqLevelB_n,
  input  wire logic                extReqEdge_n,
  input  wire logic                serialAltReqA_n,
  input  wire logic                serialAltReqB_n,
  input  wire logic                altFlagInput,
  output logic                     altFlagOutput,
  output logic                     altFlagInputQ,
  input  wire logic                serialPortBAltMode,
  input  wire logic                altFlagOutBit,
  input  wire logic                serialATxReq,
  input  wire logic                serialARxReq,
  input  wire logic                serialBTxReq,
  input  wire logic                serialBRxReq,
  input  wire logic                byteDmaReq,
  input  wire logic                timerReq,
  input  wire logic                powerdownRequestPin_n,
  input  wire logic                maskWr,
  input  wire logic [NUM_SRC-1:0]  maskWrData,
  output logic [NUM_SRC-1:0]       intMaskReg,
  input  wire logic                ctrlWr,
  input  wire logic [CTL_W-1:0]    ctrlWrData,
  output logic [CTL_W-1:0]         intControlReg,
  input  wire logic                forceClearWr,
  input  wire logic [NUM_LVL-1:0]  forceBits,
  input  wire logic [NUM_LVL-1:0]  clearBits,
  input  wire logic                globalIntOnInstr,
  input  wire logic                globalIntOffInstr,
  output logic                     globalIntEn,
  input  wire logic                modeStatusWr,
  input  wire logic [MODE_STATUS_REG_W-1:0]  modeStatusWrData,
  output logic [MODE_STATUS_REG_W-1:0]       modeStatusReg,
  input  wire logic                instrDone,
  input  wire logic                loopPush,
  input  wire logic                stackPop,
  input  wire logic                intReturn,
  input  wire logic [STATUS_W-1:0] statusIn,
  output logic [STATUS_W-1:0]      statusTop,
  output logic                     stackEmpty,
  output logic                     stackOverflow,
  output logic                     vecValid,
  output logic [15:0]              vecAddr,
  input  wire logic                idleInstr,
  input  wire logic [1:0]          idleDivSel,
  input  wire logic                idleSlow,
  input  wire logic                powerdownInstr,
  input  wire logic                oscDisabled,
  input  wire logic                powerupContextSelect,
  output logic                     contextClear,
  output logic                     powerdownAck,
  output logic                     coreStall,
  output logic                     periphClkEn,
  input  wire logic                clockOutDisableBit,
  output logic                     cycleClockOutput
);
  if (STATUS_W < 1 || STATUS_W > 64)
  begin : g_bad_status_w
    $error("STATUS_W out of range");
  end

  logic [NUM_LVL-1:0]        reqRaw;
  logic [NUM_LVL-1:0]        edgeSel;
  logic [NUM_LVL-1:0]        pending;
  logic [NUM_LVL-1:0]        ackVec;
  logic [NUM_LVL-1:0]        eligible;
  logic [NUM_LVL-1:0]        inSvc_q, inSvc_d;
  logic [NUM_SRC-1:0]        mask_q, mask_d;
  logic [CTL_W-1:0]          ctl_q, ctl_d;
  logic [MODE_STATUS_REG_W-1:0]        mode_status_reg_q, mode_status_reg_d;
  logic                      gEn_q, gEn_d;
  logic                      mBlock_q, mBlock_d;
  logic                      resetVec_q, resetVec_d;
  logic                      vecValid_q, vecValid_d;
  logic [15:0]               vecAddr_q, vecAddr_d;
  dilpc_state_t              state_q, state_d;
  logic                      slow_q, slow_d;
  logic [1:0]                divSel_q, divSel_d;
  logic [DIV_W-1:0]          divCnt_q, divCnt_d;
  logic [RECOVER_W-1:0]      recCnt_q, recCnt_d;
  logic                      ctxClr_q, ctxClr_d;
  logic                      cycle_clock_output_q, cycle_clock_output_d;
  logic                      pdPrev_q, pdPrev_d;
  logic [STATUS_W-1:0]       stack_q [STACK_DEPTH];
  logic [STATUS_W-1:0]       stack_d [STACK_DEPTH];
  logic [3:0]                sp_q, sp_d;
  logic                      ovf_q, ovf_d;
  logic                      slowTick;
  logic                      take;
  logic                      found;
  logic [3:0]                selIdx;
  logic [3:0]                svcIdx;
  logic                      push;
  logic                      pop;
  logic [NUM_LVL-1:0]        lvlReq;
  logic [NUM_LVL-1:0]        lvlEdge;

  // source mapping; second port requests come from its pins in alternate mode
  always_comb
  begin
    reqRaw                = '0;
    edgeSel               = '1;
    reqRaw[SRC_PROG_A]    = !extReqProgA_n;
    edgeSel[SRC_PROG_A]   = ctl_q[CTL_EDGE_PROG];
    reqRaw[SRC_LEVEL_B]   = !extReqLevelB_n;
    edgeSel[SRC_LEVEL_B]  = 1'b0;
    reqRaw[SRC_LEVEL_A]   = !extReqLevelA_n;
    edgeSel[SRC_LEVEL_A]  = 1'b0;
    reqRaw[SRC_SPA_TX]    = serialATxReq;
    reqRaw[SRC_SPA_RX]    = serialARxReq;
    reqRaw[SRC_EDGE]      = !extReqEdge_n;
    reqRaw[SRC_BYTE_MEM_DMA]      = byteDmaReq;
    reqRaw[SRC_TIMER]     = timerReq;
    if (serialPortBAltMode)
    begin
      reqRaw[SRC_SPB_TX]  = !serialAltReqB_n;
      reqRaw[SRC_SPB_RX]  = !serialAltReqA_n;
      edgeSel[SRC_SPB_TX] = ctl_q[CTL_EDGE_B];
      edgeSel[SRC_SPB_RX] = ctl_q[CTL_EDGE_A];
    end
    else
    begin
      reqRaw[SRC_SPB_TX]  = serialBTxReq;
      reqRaw[SRC_SPB_RX]  = serialBRxReq;
    end
    reqRaw[NUM_SRC]       = !powerdownRequestPin_n;
  end

  // cells sit in priority order: level 0 is power-down, level i+1 is source i
  assign lvlReq  = {reqRaw[NUM_SRC-1:0], reqRaw[NUM_SRC]};
  assign lvlEdge = {edgeSel[NUM_SRC-1:0], edgeSel[NUM_SRC]};

  genvar gi;
  generate
    for (gi = 0; gi < NUM_LVL; gi++)
    begin : g_req
      dilpc_req_cell u_cell (
        .sys_clk  (sys_clk),
        .reset_n  (reset_n),
        .clkEn    (clkEn),
        .reqIn    (lvlReq[gi]),
        .edgeMode (lvlEdge[gi]),
        .setPend  (forceClearWr & forceBits[gi]),
        .clrPend  (forceClearWr & clearBits[gi]),
        .ack      (ackVec[gi]),
        .pending  (pending[gi])
      );
    end
  endgenerate

  // slow idle divider; a tick marks one slowed processor cycle
  always_comb
  begin
    slowTick = !slow_q || (divCnt_q == '0);
  end

  // priority pick: power-down (level 0 here) then sources in index order
  always_comb
  begin
    eligible = pending & {mask_q, 1'b1};
    found    = 1'b0;
    selIdx   = 4'h0;
    svcIdx   = 4'hf;
    for (int i = NUM_LVL - 1; i >= 0; i--)
    begin
      if (eligible[i])
      begin
        found  = 1'b1;
        selIdx = 4'(i);
      end
      if (inSvc_q[i])
      begin
        svcIdx = 4'(i);
      end
    end
  end

  always_comb
  begin
    take = 1'b0;
    if (found && gEn_q && !mBlock_q && !resetVec_q)
    begin
      if (ctl_q[CTL_NEST])
        take = (selIdx < svcIdx);
      else
        take = (inSvc_q == '0);
      if (state_q == DILPC_IDLE)
        take = take && slowTick;
      else if (state_q != DILPC_RUN)
        take = 1'b0;
    end
  end

  always_comb
  begin
    ackVec = '0;
    if (take)
      ackVec = NUM_LVL'(1) << selIdx;
    push = take || loopPush;
    pop  = intReturn || stackPop;
  end

  // control, state and vector next values
  always_comb
  begin
    mask_d     = maskWr ? maskWrData : mask_q;
    mBlock_d   = maskWr ? 1'b1 : (instrDone ? 1'b0 : mBlock_q);
    ctl_d      = ctrlWr ? ctrlWrData : ctl_q;
    mode_status_reg_d    = modeStatusWr ? modeStatusWrData : mode_status_reg_q;
    gEn_d      = gEn_q;
    if (globalIntOffInstr)
      gEn_d = 1'b0;
    if (globalIntOnInstr)
      gEn_d = 1'b1;
    inSvc_d    = inSvc_q | ackVec;
    if (intReturn && svcIdx != 4'hf)
      inSvc_d[svcIdx] = 1'b0;
    resetVec_d = 1'b0;
    vecValid_d = resetVec_q || take;
    vecAddr_d  = vecAddr_q;
    if (resetVec_q)
      vecAddr_d = VEC_RESET;
    else if (take)
      vecAddr_d = (selIdx == 4'h0) ? VEC_PDOWN
                                   : 16'(VEC_FIRST + VEC_STEP * 16'(selIdx - 4'h1));
    state_d    = state_q;
    slow_d     = slow_q;
    divSel_d   = divSel_q;
    recCnt_d   = recCnt_q;
    ctxClr_d   = 1'b0;
    pdPrev_d   = !powerdownRequestPin_n;
    divCnt_d   = slowTick ? (DIV_W'(16) << divSel_q) - DIV_W'(1) : divCnt_q - DIV_W'(1);
    case (state_q)
      DILPC_RUN:
      begin
        if (powerdownInstr)
          state_d = DILPC_PDOWN;
        else if (idleInstr)
        begin
          state_d  = DILPC_IDLE;
          slow_d   = idleSlow;
          divSel_d = idleDivSel;
          divCnt_d = '0;
        end
      end
      DILPC_IDLE:
      begin
        if (take)
        begin
          state_d = DILPC_RUN;
          slow_d  = 1'b0;
        end
      end
      DILPC_PDOWN:
      begin
        // a fresh pin assertion wakes the core
        if (!powerdownRequestPin_n && !pdPrev_q)
        begin
          state_d  = DILPC_RECOVER;
          recCnt_d = oscDisabled ? RECOVER_W'(RECOVER_OSC_CYC) : RECOVER_W'(RECOVER_RUN_CYC);
        end
      end
      DILPC_RECOVER:
      begin
        recCnt_d = recCnt_q - RECOVER_W'(1);
        if (recCnt_q == RECOVER_W'(1))
        begin
          state_d  = DILPC_RUN;
          ctxClr_d = powerupContextSelect;
        end
      end
      default:
        state_d = DILPC_RUN;
    endcase
    cycle_clock_output_d = slowTick ? !cycle_clock_output_q : cycle_clock_output_q;
  end

  // status stack
  always_comb
  begin
    stack_d = stack_q;
    sp_d    = sp_q;
    ovf_d   = ovf_q;
    if (push && !pop)
    begin
      if (sp_q == 4'(STACK_DEPTH))
        ovf_d = 1'b1;
      else
      begin
        stack_d[sp_q] = statusIn;
        sp_d          = sp_q + 4'h1;
      end
    end
    else if (pop && !push && sp_q != 4'h0)
      sp_d = sp_q - 4'h1;
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      mask_q     <= MASK_RESET;
      mBlock_q   <= 1'b0;
      ctl_q      <= CTL_RESET;
      mode_status_reg_q    <= '0;
      gEn_q      <= 1'b1;
      inSvc_q    <= '0;
      resetVec_q <= 1'b1;
      vecValid_q <= 1'b0;
      vecAddr_q  <= VEC_RESET;
      state_q    <= DILPC_RUN;
      slow_q     <= 1'b0;
      divSel_q   <= 2'h0;
      divCnt_q   <= '0;
      recCnt_q   <= '0;
      ctxClr_q   <= 1'b0;
      cycle_clock_output_q   <= 1'b0;
      pdPrev_q   <= 1'b0;
      sp_q       <= 4'h0;
      ovf_q      <= 1'b0;
      for (int k = 0; k < STACK_DEPTH; k++)
        stack_q[k] <= '0;
    end
    else if (clkEn)
    begin
      mask_q     <= mask_d;
      mBlock_q   <= mBlock_d;
      ctl_q      <= ctl_d;
      mode_status_reg_q    <= mode_status_reg_d;
      gEn_q      <= gEn_d;
      inSvc_q    <= inSvc_d;
      resetVec_q <= resetVec_d;
      vecValid_q <= vecValid_d;
      vecAddr_q  <= vecAddr_d;
      state_q    <= state_d;
      slow_q     <= slow_d;
      divSel_q   <= divSel_d;
      divCnt_q   <= divCnt_d;
      recCnt_q   <= recCnt_d;
      ctxClr_q   <= ctxClr_d;
      cycle_clock_output_q   <= cycle_clock_output_d;
      pdPrev_q   <= pdPrev_d;
      sp_q       <= sp_d;
      ovf_q      <= ovf_d;
      stack_q    <= stack_d;
    end
  end

  assign intMaskReg       = mask_q;
  assign intControlReg    = ctl_q;
  assign modeStatusReg    = mode_status_reg_q;
  assign globalIntEn      = gEn_q;
  assign vecValid         = vecValid_q;
  assign vecAddr          = vecAddr_q;
  assign contextClear     = ctxClr_q;
  assign powerdownAck     = (state_q == DILPC_PDOWN);
  assign coreStall        = (state_q != DILPC_RUN);
  assign periphClkEn      = slowTick;
  assign cycleClockOutput = cycle_clock_output_q & !clockOutDisableBit;
  assign altFlagOutput    = serialPortBAltMode & altFlagOutBit;
  assign altFlagInputQ    = serialPortBAltMode & altFlagInput;
  assign statusTop        = (sp_q == 4'h0) ? '0 : stack_q[sp_q - 4'h1];
  assign stackEmpty       = (sp_q == 4'h0);
  assign stackOverflow    = ovf_q;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  AST_PD_VECTOR: assert property (clkEn && take && selIdx == 4'h0 |=> vecValid && vecAddr == 16'h002c)
    else $error("power-down vector wrong");
  AST_MASK_GATES: assert property (take && selIdx != 4'h0 |-> mask_q[selIdx - 4'h1])
    else $error("masked source taken");
  AST_HIGHEST: assert property (take |-> (eligible & ((NUM_LVL'(1) << selIdx) - NUM_LVL'(1))) == '0)
    else $error("lower priority chosen");
  AST_MASK_BLOCK: assert property (clkEn && maskWr |=> !take)
    else $error("interrupt taken after mask write");
  AST_SEQUENTIAL: assert property (take && !ctl_q[CTL_NEST] |-> inSvc_q == '0)
    else $error("nested while sequential");
  AST_GLOBAL_OFF: assert property (!gEn_q |-> !take)
    else $error("taken while disabled");
  AST_STACK_PUSH: assert property (clkEn && take && !pop && sp_q < 4'(STACK_DEPTH) |=> sp_q == $past(sp_q) + 4'h1)
    else $error("stack not pushed");
  AST_RECOVER_LEN: assert property (clkEn && state_q == DILPC_PDOWN && state_d == DILPC_RECOVER && !oscDisabled
                                    |=> recCnt_q == RECOVER_W'(RECOVER_RUN_CYC))
    else $error("recovery count wrong");
  AST_EDGE_ACK: assert property (clkEn && take && selIdx == 4'(SRC_EDGE + 1) && !(forceClearWr && forceBits[SRC_EDGE + 1])
                                 && !(!extReqEdge_n && g_req[SRC_EDGE + 1].u_cell.reqPrev_q == 1'b0)
                                 |=> !pending[SRC_EDGE + 1])
    else $error("edge latch kept after vector");
  AST_SLOW_WAKE: assert property (take && state_q == DILPC_IDLE |-> slowTick)
    else $error("slow idle woke off tick");
  AST_SLOW_TICK: assert property (slow_q && periphClkEn && !take |=> (!periphClkEn) [*8])
    else $error("slow idle ticks too close");
  AST_CYCLE_CLOCK_OUTPUT_OFF: assert property (clockOutDisableBit |-> !cycleClockOutput)
    else $error("clock output not disabled");

  COV_NEST: cover property (take && inSvc_q != '0);
  COV_IDLE_WAKE: cover property (state_q == DILPC_IDLE && take);
  COV_PD_EXIT: cover property (state_q == DILPC_RECOVER ##1 state_q == DILPC_RUN);
  COV_SLOW_WAKE: cover property (slow_q && take);
endmodule : dilpc_ctrl

// File: test/dilpc_src_model.sv
// partner model: external request pins and on-chip peripheral request sources
// assumes the bench drives its controls just after rising edges of sys_clk
`timescale 1ns/1ps
module dilpc_src_model (
  input  wire logic       sys_clk,
  input  wire logic [5:0] periphPulse,
  input  wire logic [5:0] pinLevel,
  output logic [5:0]      periphReq,
  output logic [5:0]      pinReq_n
);
  logic [5:0] hold_q;
  // a peripheral holds its request for two cycles, then drops it
  always_ff @(posedge sys_clk) hold_q <= periphPulse;
  assign periphReq = periphPulse | hold_q;
  // pins are pulled up and idle high; the bench paces requests to the service rate
  assign pinReq_n = ~pinLevel;
endmodule : dilpc_src_model

// File: test/tb.sv
// self-checking bench for the interrupt and low-power controller
// assumes the request source model beside it
`timescale 1ns/1ps
module tb;
  import dilpc_pkg::*;
  logic sys_clk = 0, reset_n = 0, clkEn = 1, altFlagInput = 0, serialPortBAltMode = 0, altFlagOutBit = 0;
  logic powerdownRequestPin_n = 1, maskWr = 0, ctrlWr = 0, forceClearWr = 0, globalIntOnInstr = 0;
  logic globalIntOffInstr = 0, modeStatusWr = 0, instrDone = 0, loopPush = 0, stackPop = 0, intReturn = 0;
  logic idleInstr = 0, idleSlow = 0, powerdownInstr = 0, oscDisabled = 0, powerupContextSelect = 0;
  logic clockOutDisableBit = 0, altFlagOutput, altFlagInputQ, globalIntEn, stackEmpty, stackOverflow;
  logic vecValid, contextClear, powerdownAck, coreStall, periphClkEn, cycleClockOutput, ccSeen;
  logic [9:0] maskWrData = 0, intMaskReg;
  logic [3:0] ctrlWrData = 0, intControlReg;
  logic [10:0] forceBits = 0, clearBits = 0;
  logic [6:0] modeStatusWrData = 0, modeStatusReg;
  logic [15:0] statusIn = 16'h1234, statusTop, vecAddr;
  logic [1:0] idleDivSel = 0;
  logic [5:0] periphPulse = 0, pinLevel = 0, periphReq, pinReq_n;
  int n_errors = 0, n_checks = 0, k;

  dilpc_src_model src (.sys_clk, .periphPulse, .pinLevel, .periphReq, .pinReq_n);
  dilpc_ctrl uut (.sys_clk, .reset_n, .clkEn, .extReqProgA_n(pinReq_n[0]), .extReqLevelA_n(pinReq_n[1]),
    .extReqLevelB_n(pinReq_n[2]), .extReqEdge_n(pinReq_n[3]), .serialAltReqA_n(pinReq_n[4]),
    .serialAltReqB_n(pinReq_n[5]), .altFlagInput, .altFlagOutput, .altFlagInputQ, .serialPortBAltMode,
    .altFlagOutBit, .serialATxReq(periphReq[0]), .serialARxReq(periphReq[1]), .serialBTxReq(periphReq[2]),
    .serialBRxReq(periphReq[3]), .byteDmaReq(periphReq[4]), .timerReq(periphReq[5]),
    .powerdownRequestPin_n, .maskWr, .maskWrData, .intMaskReg, .ctrlWr, .ctrlWrData, .intControlReg,
    .forceClearWr, .forceBits, .clearBits, .globalIntOnInstr, .globalIntOffInstr, .globalIntEn,
    .modeStatusWr, .modeStatusWrData, .modeStatusReg, .instrDone, .loopPush, .stackPop, .intReturn,
    .statusIn, .statusTop, .stackEmpty, .stackOverflow, .vecValid, .vecAddr, .idleInstr, .idleDivSel,
    .idleSlow, .powerdownInstr, .oscDisabled, .powerupContextSelect, .contextClear, .powerdownAck,
    .coreStall, .periphClkEn, .clockOutDisableBit, .cycleClockOutput);

  always #2.5 sys_clk = ~sys_clk;

  task automatic chk(input bit ok, input string m);
    n_checks++;
    if (!ok)
    begin
      n_errors++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask : chk

  task automatic wait_vec(input logic [15:0] a);
    int n = 0;
    do @(posedge sys_clk) #1; while (vecValid !== 1'b1 && ++n < 40);
    chk(vecValid === 1'b1 && vecAddr === a, "vector missing or wrong");
  endtask : wait_vec

  task automatic no_vec(input int n);
    int hit = 0;
    repeat (n) @(posedge sys_clk) #1 hit |= (vecValid !== 1'b0);
    chk(hit == 0, "vector not expected");
  endtask : no_vec

  task automatic ret;
    @(posedge sys_clk) intReturn <= 1;
    @(posedge sys_clk) intReturn <= 0;
  endtask : ret

  task automatic fc(input logic [10:0] f, input logic [10:0] c);
    @(posedge sys_clk);
    forceClearWr <= 1;
    forceBits <= f;
    clearBits <= c;
    @(posedge sys_clk) forceClearWr <= 0;
  endtask : fc

  task automatic t_mask;
    @(posedge sys_clk) periphPulse <= 6'h20;
    @(posedge sys_clk) periphPulse <= 6'h00;
    no_vec(10);
    fc(11'h001, 11'h000);
    wait_vec(VEC_PDOWN);
    chk(stackEmpty === 1'b0 && statusTop === 16'h1234, "status push");
    ret();
    @(posedge sys_clk) #1 chk(stackEmpty === 1'b1, "status pop");
  endtask : t_mask

  task automatic t_block;
    @(posedge sys_clk);
    maskWr <= 1;
    maskWrData <= 10'h3ff;
    @(posedge sys_clk) maskWr <= 0;
    no_vec(6);
    chk(intMaskReg === 10'h3ff, "mask");
    @(posedge sys_clk) instrDone <= 1;
    @(posedge sys_clk) instrDone <= 0;
    wait_vec(16'h0028);
    ret();
    @(posedge sys_clk) pinLevel <= 6'h06;
    wait_vec(16'h0008);
    @(posedge sys_clk) pinLevel <= 6'h02;
    no_vec(5);
    ret();
    wait_vec(16'h000c);
    @(posedge sys_clk) pinLevel <= 6'h00;
    ret();
    no_vec(5);
  endtask : t_block

  task automatic t_global;
    @(posedge sys_clk) globalIntOffInstr <= 1;
    @(posedge sys_clk) globalIntOffInstr <= 0;
    fc(11'h041, 11'h000);
    no_vec(5);
    fc(11'h000, 11'h040);
    @(posedge sys_clk) globalIntOnInstr <= 1;
    @(posedge sys_clk) globalIntOnInstr <= 0;
    wait_vec(VEC_PDOWN);
    ret();
    no_vec(8);
    @(posedge sys_clk) pinLevel <= 6'h08;
    wait_vec(16'h0018);
    @(posedge sys_clk) pinLevel <= 6'h00;
    ret();
    no_vec(5);
  endtask : t_global

  task automatic t_idle_alt;
    @(posedge sys_clk) idleInstr <= 1;
    @(posedge sys_clk) idleInstr <= 0;
    #1 chk(coreStall === 1'b1, "idle stall");
    @(posedge sys_clk) periphPulse <= 6'h02;
    @(posedge sys_clk) periphPulse <= 6'h00;
    wait_vec(16'h0014);
    chk(coreStall === 1'b0, "idle wake");
    ret();
    @(posedge sys_clk);
    idleInstr <= 1;
    idleSlow <= 1;
    @(posedge sys_clk);
    idleInstr <= 0;
    idleSlow <= 0;
    k = 0;
    repeat (32) @(posedge sys_clk) #1 k += periphClkEn;
    chk(k == 2, "slow tick rate");
    @(posedge sys_clk) periphPulse <= 6'h02;
    @(posedge sys_clk) periphPulse <= 6'h00;
    no_vec(8);
    wait_vec(16'h0014);
    ret();
    @(posedge sys_clk);
    serialPortBAltMode <= 1;
    altFlagOutBit <= 1;
    altFlagInput <= 1;
    pinLevel <= 6'h20;
    wait_vec(16'h0020);
    chk(altFlagOutput === 1'b1 && altFlagInputQ === 1'b1, "alt flags");
    @(posedge sys_clk) pinLevel <= 6'h00;
    ret();
    #1 ccSeen = cycleClockOutput;
    @(posedge sys_clk) #1 chk(cycleClockOutput === ~ccSeen, "clock out");
    @(posedge sys_clk) clockOutDisableBit <= 1;
    repeat (2) @(posedge sys_clk) #1 chk(cycleClockOutput === 1'b0, "clock out off");
  endtask : t_idle_alt

  task automatic t_nest;
    @(posedge sys_clk);
    ctrlWr <= 1;
    ctrlWrData <= 4'hc;
    @(posedge sys_clk);
    ctrlWr <= 0;
    pinLevel <= 6'h10;
    wait_vec(16'h0024);
    chk(intControlReg === 4'hc, "control");
    @(posedge sys_clk) pinLevel <= 6'h11;
    wait_vec(16'h0004);
    @(posedge sys_clk) pinLevel <= 6'h00;
    ret();
    ret();
    #1 chk(stackEmpty === 1'b1, "nested pops");
    no_vec(5);
  endtask : t_nest

  task automatic t_stack;
    @(posedge sys_clk);
    loopPush <= 1;
    modeStatusWr <= 1;
    modeStatusWrData <= 7'h5a;
    @(posedge sys_clk) modeStatusWr <= 0;
    repeat (12) @(posedge sys_clk);
    loopPush <= 0;
    stackPop <= 1;
    #1 chk(stackOverflow === 1'b1 && statusTop === 16'h1234, "stack overflow");
    repeat (12) @(posedge sys_clk);
    stackPop <= 0;
    #1 chk(stackEmpty === 1'b1 && modeStatusReg === 7'h5a, "stack pops");
  endtask : t_stack

  task automatic t_pdown;
    @(posedge sys_clk);
    powerupContextSelect <= 1;
    powerdownInstr <= 1;
    @(posedge sys_clk) powerdownInstr <= 0;
    #1 chk(powerdownAck === 1'b1, "power-down ack");
    @(posedge sys_clk) powerdownRequestPin_n <= 0;
    ccSeen = 0;
    for (k = 0; k < 300 && coreStall !== 1'b0; k++)
      @(posedge sys_clk) #1 ccSeen |= contextClear;
    chk(k >= RECOVER_RUN_CYC && k <= RECOVER_RUN_CYC + 4, "recovery time");
    chk(ccSeen === 1'b1, "context clear");
    @(posedge sys_clk);
    powerdownInstr <= 1;
    powerdownRequestPin_n <= 1;
    oscDisabled <= 1;
    @(posedge sys_clk) powerdownInstr <= 0;
    @(posedge sys_clk) powerdownRequestPin_n <= 0;
    for (k = 0; k < 3000 && coreStall !== 1'b0; k++)
      @(posedge sys_clk) #1;
    chk(k >= RECOVER_OSC_CYC && k <= RECOVER_OSC_CYC + 4, "oscillator recovery time");
    @(posedge sys_clk);
    powerdownInstr <= 1;
    powerdownRequestPin_n <= 1;
    @(posedge sys_clk) powerdownInstr <= 0;
    #1 chk(powerdownAck === 1'b1, "power-down ack again");
    @(posedge sys_clk) reset_n <= 0;
    #1 chk(powerdownAck === 1'b0, "reset ends power-down");
    @(posedge sys_clk) reset_n <= 1;
    wait_vec(VEC_RESET);
    chk(intMaskReg === MASK_RESET && stackEmpty === 1'b1 && stackOverflow === 1'b0
        && modeStatusReg === 7'h00, "mid-run reset");
  endtask : t_pdown

  task automatic print_verdict;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : print_verdict

  initial
  begin
    repeat (5) @(posedge sys_clk);
    reset_n <= 1;
    wait_vec(VEC_RESET);
    chk(globalIntEn === 1'b1, "global enable");
    chk(intMaskReg === MASK_RESET && stackEmpty === 1'b1 && modeStatusReg === 7'h00, "reset");
    t_mask();
    t_block();
    t_global();
    t_idle_alt();
    t_nest();
    t_stack();
    t_pdown();
    print_verdict();
  end

  initial
  begin
    #60000;
    n_errors++;
    $display("[FAIL] %0t watchdog expired", $time);
    print_verdict();
  end
endmodule : tb
